/* verilog/sel_mapper.sv */
// Sensor event to lamp mapping, segment tracking and wake sequence logic.
`timescale 1ns/1ps
module sel_mapper
  import sel_pkg::*;
#(
  parameter int             PINS       = 8,
  parameter int             POS_W      = 10,
  parameter logic [9:0]     SLIDER_TOP = 10'h3FF
)
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             reg_wr_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  output logic      [7:0]       reg_rdata_out,
  input  wire logic             scan_done_in,
  input  wire logic [11:0]      button_touch_in,
  input  wire logic             slider_touch_in,
  input  wire logic             move_low_in,
  input  wire logic             move_high_in,
  input  wire logic [POS_W-1:0] slider_pos_in,
  input  wire logic             doze_in,
  output logic                  wake_out,
  output logic      [PINS-1:0]  general_output_pin_out
);

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  logic [2:0]  wake_sequence_length, next_wake_len;
  logic [23:0] wake_keys, next_wake_keys;
  logic [31:0] lamp_map, next_lamp_map;
  logic [14:0] event_set_a_members, next_set_a;
  logic [14:0] event_set_b, next_set_b;
  logic [7:0]  segment_change_hysteresis, next_hyst;
  logic [7:0]  autolight, next_autolight;
  logic [7:0]  next_rdata;

  always_comb begin
    next_wake_len  = wake_sequence_length;
    next_wake_keys = wake_keys;
    next_lamp_map  = lamp_map;
    next_set_a     = event_set_a_members;
    next_set_b     = event_set_b;
    next_hyst      = segment_change_hysteresis;
    next_autolight = autolight;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_WAKE_LEN:  next_wake_len = reg_wdata_in[2:0];
        ADDR_WAKE_BYTE0: next_wake_keys[23:16] = reg_wdata_in;
        ADDR_WAKE_BYTE1: next_wake_keys[15:8] = reg_wdata_in;
        ADDR_WAKE_BYTE2: next_wake_keys[7:0] = reg_wdata_in;
        ADDR_MAP0:      next_lamp_map[31:24] = reg_wdata_in;
        ADDR_MAP1:      next_lamp_map[23:16] = reg_wdata_in;
        ADDR_MAP2:      next_lamp_map[15:8] = reg_wdata_in;
        ADDR_MAP3:      next_lamp_map[7:0] = reg_wdata_in;
        ADDR_SET_A_UP:  next_set_a[14:8] = reg_wdata_in[6:0];
        ADDR_SET_A_LO:  next_set_a[7:0] = reg_wdata_in;
        ADDR_SET_B_UP:  next_set_b[14:8] = reg_wdata_in[6:0];
        ADDR_SET_B_LO:  next_set_b[7:0] = reg_wdata_in;
        ADDR_HYST:      next_hyst = reg_wdata_in;
        ADDR_AUTOLIGHT: next_autolight = reg_wdata_in;
        default:        next_wake_len = wake_sequence_length;
      endcase
    end
    case (reg_addr_in)
      ADDR_WAKE_LEN:  next_rdata = {5'h00, wake_sequence_length};
      ADDR_WAKE_BYTE0: next_rdata = wake_keys[23:16];
      ADDR_WAKE_BYTE1: next_rdata = wake_keys[15:8];
      ADDR_WAKE_BYTE2: next_rdata = wake_keys[7:0];
      ADDR_MAP0:      next_rdata = lamp_map[31:24];
      ADDR_MAP1:      next_rdata = lamp_map[23:16];
      ADDR_MAP2:      next_rdata = lamp_map[15:8];
      ADDR_MAP3:      next_rdata = lamp_map[7:0];
      ADDR_SET_A_UP:  next_rdata = {1'b0, event_set_a_members[14:8]};
      ADDR_SET_A_LO:  next_rdata = event_set_a_members[7:0];
      ADDR_SET_B_UP:  next_rdata = {1'b0, event_set_b[14:8]};
      ADDR_SET_B_LO:  next_rdata = event_set_b[7:0];
      ADDR_HYST:      next_rdata = segment_change_hysteresis;
      ADDR_AUTOLIGHT: next_rdata = autolight;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wake_sequence_length      <= RST_WAKE_LEN;
      wake_keys                 <= RST_WAKE_KEYS;
      lamp_map                  <= RST_MAP;
      event_set_a_members       <= RST_SET;
      event_set_b               <= RST_SET;
      segment_change_hysteresis <= RST_HYST;
      autolight                 <= RST_AUTOLIGHT;
      reg_rdata_out             <= 8'h00;
    end else begin
      wake_sequence_length      <= next_wake_len;
      wake_keys                 <= next_wake_keys;
      lamp_map                  <= next_lamp_map;
      event_set_a_members       <= next_set_a;
      event_set_b               <= next_set_b;
      segment_change_hysteresis <= next_hyst;
      autolight                 <= next_autolight;
      reg_rdata_out             <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Slider move state, event edges and set levels
  // ---------------------------------------------------------------------------
  logic        low_st, high_st, next_low, next_high;
  logic [11:0] prev_btn;
  logic        prev_touch;
  logic [11:0] btn_rise;
  logic        touch_rise, any_event, set_a_lvl, set_b_lvl;

  always_comb begin
    next_low  = low_st;
    next_high = high_st;
    if (scan_done_in) begin
      if (move_low_in) begin
        next_low = 1'b1;
      end else if (move_high_in || !slider_touch_in) begin
        next_low = 1'b0;
      end
      if (move_high_in) begin
        next_high = 1'b1;
      end else if (move_low_in || !slider_touch_in) begin
        next_high = 1'b0;
      end
    end
    btn_rise   = button_touch_in & ~prev_btn;
    touch_rise = slider_touch_in & !prev_touch;
    any_event  = (|btn_rise) | touch_rise | move_low_in | move_high_in;
    set_a_lvl  = (|(event_set_a_members[11:0] & button_touch_in))
               | (event_set_a_members[SET_BIT_LOW] & next_low)
               | (event_set_a_members[SET_BIT_HIGH] & next_high);
    set_b_lvl  = (|(event_set_b[11:0] & button_touch_in))
               | (event_set_b[SET_BIT_LOW] & next_low)
               | (event_set_b[SET_BIT_HIGH] & next_high)
               | (event_set_b[SET_BIT_TOP] & slider_touch_in);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      low_st     <= 1'b0;
      high_st    <= 1'b0;
      prev_btn   <= 12'h000;
      prev_touch <= 1'b0;
    end else begin
      low_st     <= next_low;
      high_st    <= next_high;
      prev_btn   <= scan_done_in ? button_touch_in : prev_btn;
      prev_touch <= scan_done_in ? slider_touch_in : prev_touch;
    end
  end

  // ---------------------------------------------------------------------------
  // Slider segments
  // ---------------------------------------------------------------------------
  logic             seg_mode;
  logic [PINS-1:0]  seg_pin;
  logic [3:0]       seg_count;
  logic [3:0]       rank [PINS];
  logic [3:0]       cur_seg, next_seg, cand;
  logic [POS_W+7:0] pos_c, prod, lo_b, hi_b, margin;

  // Segment mode needs the segment bit to be the only set-A member.
  assign seg_mode = event_set_a_members[SET_BIT_TOP] && (event_set_a_members[13:0] == 14'h0000);

  always_comb begin
    seg_count = 4'h0;
    pos_c     = {8'h00, (slider_pos_in > SLIDER_TOP) ? SLIDER_TOP : slider_pos_in};
    for (int i = 0; i < PINS; i++) begin
      seg_pin[i] = seg_mode && (lamp_map[4*i +: 4] == CODE_SET_A) && autolight[i];
      rank[i]    = seg_count;
      seg_count  = seg_count + {3'h0, seg_pin[i]};
    end
    margin   = ((POS_W+8)'(SLIDER_TOP) * (POS_W+8)'((segment_change_hysteresis > HYST_MAX) ?
               HYST_MAX : segment_change_hysteresis)) / (POS_W+8)'(100);
    prod     = pos_c * (POS_W+8)'(seg_count);
    cand     = 4'h0;
    lo_b     = '0;
    hi_b     = '0;
    next_seg = cur_seg;
    if (seg_count != 4'h0) begin
      cand = 4'((prod / ((POS_W+8)'(SLIDER_TOP) + 1'b1)));
      lo_b = ((POS_W+8)'(SLIDER_TOP) * (POS_W+8)'(cur_seg)) / (POS_W+8)'(seg_count);
      hi_b = ((POS_W+8)'(SLIDER_TOP) * (POS_W+8)'(cur_seg + 4'h1)) / (POS_W+8)'(seg_count);
      if (scan_done_in && slider_touch_in) begin
        if (touch_rise || cur_seg >= seg_count) begin
          next_seg = cand;
        end else if (cand > cur_seg && pos_c >= hi_b + margin) begin
          next_seg = cand;
        end else if (cand < cur_seg && pos_c + margin <= lo_b) begin
          next_seg = cand;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cur_seg <= 4'h0;
    end else begin
      cur_seg <= next_seg;
    end
  end

  // ---------------------------------------------------------------------------
  // Output cells
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < PINS; g++) begin : g_cell
    sel_lamp_cell u_cell (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .scan_in     (scan_done_in),
      .enable_in   (autolight[g]),
      .code_in     (lamp_map[4*g +: 4]),
      .button_in   (button_touch_in),
      .set_a_in    (set_a_lvl),
      .set_b_in    (set_b_lvl),
      .low_in      (next_low),
      .high_in     (next_high),
      .seg_mode_in (seg_mode),
      .seg_on_in   (slider_touch_in && (rank[g] == next_seg)),
      .lit_out     (general_output_pin_out[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Wake sequence
  // ---------------------------------------------------------------------------
  logic [2:0] step, next_step;
  logic [3:0] key;
  logic       hit, next_wake;

  always_comb begin
    key       = wake_keys[4*step +: 4];
    hit       = ((key <= CODE_BTN_LAST) && btn_rise[key]) || ((key == KEY_TOUCH) && touch_rise)
              || ((key == KEY_LOW) && move_low_in) || ((key == KEY_HIGH) && move_high_in);
    next_step = step;
    next_wake = 1'b0;
    if (!doze_in) begin
      next_step = 3'h0;
    end else if (scan_done_in && any_event) begin
      if (wake_sequence_length == 3'h0) begin
        next_wake = 1'b1;
      end else if (wake_sequence_length <= WAKE_LEN_MAX) begin
        if (!hit) begin
          next_step = 3'h0;
        end else if (step + 3'h1 == wake_sequence_length) begin
          next_wake = 1'b1;
          next_step = 3'h0;
        end else begin
          next_step = step + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      step     <= 3'h0;
      wake_out <= 1'b0;
    end else begin
      step     <= next_step;
      wake_out <= next_wake;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_wake_scan;
    doze_in && scan_done_in && any_event;
  endsequence
  sequence s_last_key;
    s_wake_scan ##0 (wake_sequence_length inside {[1:6]}) && hit && (step + 3'h1 == wake_sequence_length);
  endsequence

  a_len_zero_wake: assert property (s_wake_scan ##0 (wake_sequence_length == 3'h0) |=> wake_out)
    else $error("no wake on event with zero length");
  a_wake_last_key: assert property (s_last_key |=> wake_out && step == 3'h0)
    else $error("last key did not wake");
  a_wake_cause: assert property (wake_out |-> $past(doze_in && scan_done_in && any_event))
    else $error("wake without a sensor event in doze");
  a_button_map: assert property (scan_done_in && autolight[0] && lamp_map[3:0] <= CODE_BTN_LAST
    |=> general_output_pin_out[0] == $past(button_touch_in[lamp_map[3:0]]))
    else $error("pin 0 does not follow its button");
  a_set_b_member: assert property (scan_done_in && autolight[4] && lamp_map[19:16] == CODE_SET_B
    && |(event_set_b[11:0] & button_touch_in) |=> general_output_pin_out[4])
    else $error("set B member did not light pin 4");
  a_set_a_select: assert property (scan_done_in && autolight[0] && lamp_map[3:0] == CODE_SET_A
    && !seg_mode |=> general_output_pin_out[0] == $past(set_a_lvl))
    else $error("set A code does not follow set A");
  a_move_low_off: assert property (scan_done_in && (move_high_in || !slider_touch_in) && !move_low_in
    |=> !low_st)
    else $error("move low state not cleared");
  a_pins_together: assert property (scan_done_in && lamp_map[3:0] == lamp_map[7:4] && autolight[1:0] == 2'b11
    && !seg_pin[0] |=> general_output_pin_out[0] == general_output_pin_out[1])
    else $error("pins with one mapping differ");
  a_seg_one_lit: assert property ($onehot0(general_output_pin_out & $past(seg_pin))
    || $past(seg_pin) != seg_pin)
    else $error("two segment pins lit at once");
  a_set_b_store: assert property (reg_wr_in && reg_addr_in == ADDR_SET_B_UP
    |=> event_set_b[14:8] == $past(reg_wdata_in[6:0]))
    else $error("set B upper byte not stored");

endmodule

/* verilog/sel_pkg.sv */
// Constants for the sensor event to lamp mapping block.
// Notes on behaviour
// - Each set-B enable bit includes (1) or excludes (0) one event; any included event fires.
// - Set-B upper byte: touch bit 6, move high 5, move low 4, buttons 11..8.
// - Every set-B member is enabled independently of all other members.
// - Segment change needs position hysteresis, 0x00..0x64 percent of top, default 0x02.
// - Wake sequence length one to six keys, each naming the expected event.
// - Wake length zero wakes on any sensor event without checking keys.
// - An output with automatic lighting follows only its mapped event or event set.
// - An output mapped to a set is controlled by any member event of that set; set-A bit 14 does nothing here unless it is the only member (segment mode).
// - Button or slider touch mapping: ON at touch, OFF at release.
// - Move low: ON at move low, OFF at move high or release; high symmetric.
// - Slider splits into as many segments as outputs mapped to the segment event.
// - Lowest pin takes lowest segment; ON while segment touched, OFF when released.
// - Mapping code 0x0C selects event set A for that output.
// - Four-bit map per pin, pin 7 high nibble first; 0x00-0x0B buttons, 0x0C-0x0F.
// - Several outputs may share one event and switch together.
// - Wake keys four bits: buttons, 0x0C touch, 0x0D low, 0x0E high; first step lowest.
package sel_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_WAKE_LEN   = 8'h33;
  localparam logic [7:0] ADDR_WAKE_BYTE0 = 8'h34;
  localparam logic [7:0] ADDR_WAKE_BYTE1 = 8'h35;
  localparam logic [7:0] ADDR_WAKE_BYTE2 = 8'h36;
  localparam logic [7:0] ADDR_MAP0       = 8'h37;
  localparam logic [7:0] ADDR_MAP1       = 8'h38;
  localparam logic [7:0] ADDR_MAP2       = 8'h39;
  localparam logic [7:0] ADDR_MAP3       = 8'h3A;
  localparam logic [7:0] ADDR_SET_A_UP   = 8'h3B;
  localparam logic [7:0] ADDR_SET_A_LO   = 8'h3C;
  localparam logic [7:0] ADDR_SET_B_UP   = 8'h3D;
  localparam logic [7:0] ADDR_SET_B_LO   = 8'h3E;
  localparam logic [7:0] ADDR_HYST       = 8'h3F;
  localparam logic [7:0] ADDR_AUTOLIGHT  = 8'h43;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  RST_WAKE_LEN   = 3'h0;
  localparam logic [23:0] RST_WAKE_KEYS  = 24'h00_0000;
  localparam logic [31:0] RST_MAP        = 32'h0000_0000;
  localparam logic [14:0] RST_SET        = 15'h0000;
  localparam logic [7:0]  RST_HYST       = 8'h02;
  localparam logic [7:0]  RST_AUTOLIGHT  = 8'hFF;
  localparam logic [7:0]  HYST_MAX       = 8'h64;

  // ---------------------------------------------------------------------------
  // Field positions and event codes
  // ---------------------------------------------------------------------------
  localparam int          SET_BIT_LOW    = 12;
  localparam int          SET_BIT_HIGH   = 13;
  localparam int          SET_BIT_TOP    = 14;
  localparam logic [3:0]  CODE_BTN_LAST  = 4'hB;
  localparam logic [3:0]  CODE_SET_A     = 4'hC;
  localparam logic [3:0]  CODE_SET_B     = 4'hD;
  localparam logic [3:0]  CODE_MOVE_LOW  = 4'hE;
  localparam logic [3:0]  CODE_MOVE_HIGH = 4'hF;
  localparam logic [3:0]  KEY_TOUCH      = 4'hC;
  localparam logic [3:0]  KEY_LOW        = 4'hD;
  localparam logic [3:0]  KEY_HIGH       = 4'hE;
  localparam logic [2:0]  WAKE_LEN_MAX   = 3'h6;

endpackage

/* verilog/sel_lamp_cell.sv */
// One output pin's automatic lighting state.
`timescale 1ns/1ps
module sel_lamp_cell
  import sel_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        scan_in,
  input  wire logic        enable_in,
  input  wire logic [3:0]  code_in,
  input  wire logic [11:0] button_in,
  input  wire logic        set_a_in,
  input  wire logic        set_b_in,
  input  wire logic        low_in,
  input  wire logic        high_in,
  input  wire logic        seg_mode_in,
  input  wire logic        seg_on_in,
  output logic             lit_out
);

  logic next_lit;

  always_comb begin
    next_lit = lit_out;
    if (scan_in) begin
      if (!enable_in) begin
        next_lit = 1'b0;
      end else if (code_in <= CODE_BTN_LAST) begin
        next_lit = button_in[code_in];
      end else begin
        case (code_in)
          CODE_SET_A:     next_lit = seg_mode_in ? seg_on_in : set_a_in;
          CODE_SET_B:     next_lit = set_b_in;
          CODE_MOVE_LOW:  next_lit = low_in;
          CODE_MOVE_HIGH: next_lit = high_in;
          default:        next_lit = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lit_out <= 1'b0;
    end else begin
      lit_out <= next_lit;
    end
  end

endmodule

/* test/sel_host.sv */
// Host model that configures the mapper through its register port.
`timescale 1ns/1ps
module sel_host (
  input  wire logic       sys_clk_in,
  output logic            reg_wr_out,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            look_out
);
  initial begin
    reg_wr_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    look_out = 1'b0;
  end
  // Write data is scrambled once the strobe drops, so stale data is never trusted.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    look_out <= 1'b1;
    @(posedge sys_clk_in);
    look_out <= 1'b0;
  endtask
  // The segment member of set A is only ever written as the sole member.
  task automatic set_a(input logic [14:0] v);
    logic [14:0] s;
    s = v;
    if (s[14] && s[13:0] != 14'h0000) s[14] = 1'b0;
    wr(8'h3B, {1'b0, s[14:8]});
    wr(8'h3C, s[7:0]);
  endtask
endmodule

/* test/sensor_event_light_mapping_test.sv */
// Self-checking bench for the sensor event to lamp mapper.
`timescale 1ns/1ps
module sensor_event_light_mapping_test;
  import sel_pkg::*;
  localparam logic [7:0]  RA [5] = '{8'h3D, 8'h3E, 8'h3F, 8'h43, 8'h50};
  localparam logic [7:0]  R0 [5] = '{8'h00, 8'h00, 8'h02, 8'hFF, 8'h00};
  localparam logic [7:0]  WD [5] = '{8'hC5, 8'hA3, 8'h64, 8'hA5, 8'h77};
  localparam logic [7:0]  R1 [5] = '{8'h45, 8'hA3, 8'h64, 8'hA5, 8'h00};
  localparam logic [31:0] MW [3] = '{32'h7654_3210, 32'hBA98_BA98, 32'hBA98_BA98};
  localparam logic [7:0]  AL [3] = '{8'hFF, 8'hFF, 8'h0F};
  localparam logic [4:0]  MV [7] = '{5'h19, 5'h16, 5'h12, 5'h00, 5'h16, 5'h19, 5'h00};
  localparam logic [12:0] SG [8] = '{{1'b1, 10'h064, 2'h1}, {1'b1, 10'h208, 2'h1}, {1'b1, 10'h258, 2'h2},
    {1'b1, 10'h1F4, 2'h2}, {1'b1, 10'h1E0, 2'h1}, {1'b0, 10'h1E0, 2'h0}, {1'b1, 10'h384, 2'h2},
    {1'b0, 10'h000, 2'h0}};
  localparam logic [4:0]  WK [9] = '{5'h03, 5'h1E, 5'h06, 5'h1E, 5'h08, 5'h1E, 5'h06, 5'h1E, 5'h0B};
  logic        sys_clk;
  logic        rst;
  logic        scan;
  logic        touch;
  logic        low;
  logic        high;
  logic        doze;
  logic [11:0] btn;
  logic [9:0]  pos;
  logic        wr_s;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        look;
  logic [7:0]  rdata;
  logic        wake;
  logic [7:0]  pins;
  logic        scan_q;
  logic        rd_q;
  logic [8:0]  exp_s [$];
  logic [7:0]  exp_r [$];
  int          n_fail;
  int          tests_run;
  sel_host i_host (.sys_clk_in(sys_clk), .reg_wr_out(wr_s), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .look_out(look));
  sel_mapper i_dut (.sys_clk_in(sys_clk), .rst_in(rst), .reg_wr_in(wr_s), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .scan_done_in(scan), .button_touch_in(btn),
    .slider_touch_in(touch), .move_low_in(low), .move_high_in(high), .slider_pos_in(pos),
    .doze_in(doze), .wake_out(wake), .general_output_pin_out(pins));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_r.push_back(want);
    i_host.rd(a);
  endtask
  task automatic map(input logic [31:0] m);
    for (int j = 0; j < 4; j++) wr(8'(8'h3A - j), m[8*j +: 8]);
  endtask
  task automatic scan_one(input logic [11:0] b, input logic t, input logic l, input logic h,
                          input logic [9:0] p, input logic [8:0] want);
    @(posedge sys_clk);
    scan <= 1'b1;
    btn <= b;
    touch <= t;
    low <= l;
    high <= h;
    pos <= p;
    exp_s.push_back(want);
    @(posedge sys_clk);
    scan <= 1'b0;
  endtask
  // Results land one edge after the scan or read that causes them.
  always @(posedge sys_clk) begin
    scan_q <= scan;
    rd_q <= look;
  end
  always @(negedge sys_clk) begin
    if (scan_q) check({wake, pins}, exp_s.pop_front());
    if (rd_q) check({1'b0, rdata}, {1'b0, exp_r.pop_front()});
  end
  initial begin
    #300_000;
    n_fail++;
    wrap_up();
  end
  initial begin
    logic [11:0] b;
    logic [14:0] sa;
    logic [14:0] sb;
    logic [7:0]  e;
    logic        t;
    rst = 1'b1;
    scan = 1'b0;
    touch = 1'b0;
    low = 1'b0;
    high = 1'b0;
    doze = 1'b0;
    btn = 12'h000;
    pos = 10'h000;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(69));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(RA[i], R0[i]);
    for (int i = 0; i < 5; i++) wr(RA[i], WD[i]);
    for (int i = 0; i < 5; i++) rd(RA[i], R1[i]);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      map(MW[k]);
      wr(8'h43, AL[k]);
      repeat (4) begin
        b = 12'($urandom);
        for (int p = 0; p < 8; p++) e[p] = b[MW[k][4*p +: 4]] & AL[k][p];
        scan_one(b, 1'b0, 1'b0, 1'b0, 10'h000, {1'b0, e});
      end
    end
    $display("test buttons done");
    map(32'hDDDD_CCCC);
    wr(8'h43, 8'hFF);
    repeat (6) begin
      sa = 15'($urandom);
      sa[14] = 1'b0;
      sb = 15'($urandom);
      i_host.set_a(sa);
      wr(8'h3D, {1'b0, sb[14:8]});
      wr(8'h3E, sb[7:0]);
      b = 12'($urandom);
      t = 1'($urandom);
      e = {{4{|({t, 2'b00, b} & sb)}}, {4{|(b & sa[11:0])}}};
      scan_one(b, t, 1'b0, 1'b0, 10'h000, {1'b0, e});
    end
    $display("test event sets done");
    map(32'h0000_00FE);
    for (int i = 0; i < 7; i++) scan_one(12'h000, MV[i][4], MV[i][3], MV[i][2], 10'h000, {7'h00, MV[i][1:0]});
    $display("test moves done");
    i_host.set_a(15'h4000);
    map(32'h0000_00CC);
    wr(8'h43, 8'h03);
    wr(8'h3F, 8'h02);
    for (int i = 0; i < 8; i++) scan_one(12'h000, SG[i][12], 1'b0, 1'b0, SG[i][11:2], {7'h00, SG[i][1:0]});
    $display("test segments done");
    wr(8'h43, 8'h00);
    @(posedge sys_clk);
    doze <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (i == 2) begin
        wr(8'h33, 8'h02);
        wr(8'h36, 8'h53);
      end
      b = (WK[i][4:1] == 4'hF) ? 12'h000 : (12'h001 << WK[i][4:1]);
      scan_one(b, 1'b0, 1'b0, 1'b0, 10'h000, {WK[i][0], 8'h00});
    end
    $display("test wake done");
    repeat (4) @(posedge sys_clk);
    wrap_up();
  end
endmodule
